/* File: logic/pcsd_defines.svh */
// Constants for the pulse-count switch decoder
`ifndef PCSD_DEFINES_SVH
`define PCSD_DEFINES_SVH
`define CLK_FREQ_MHZ     100
`define LATCH_TIMEOUT_US 500
`define OFF_TIMEOUT_US   500
`define LATCH_CYCLES     (`LATCH_TIMEOUT_US * `CLK_FREQ_MHZ)
`define OFF_CYCLES       (`OFF_TIMEOUT_US * `CLK_FREQ_MHZ)
`define TIMER_W          16
`define TIMER_ZERO       16'h0000
`define PIN_IDLE         1'h0
`define COUNT_W          6
`define COUNT_MAX        6'h3f
`define COUNT_ZERO       6'h00
`define OUTS_ALL_OFF     6'h00
`define OUTS_SMALL_MASK  6'h1f
`endif

/* File: logic/pcsd_pkg.sv */
// Types for the pulse-count switch decoder
package pcsd_pkg;
  typedef enum logic [1:0] {
    DISABLED,
    COUNTING,
    LATCHED
  } link_state_t;
endpackage

/* File: logic/pulse_count_switch_decoder.sv */
// Single-wire pulse-count decoder driving six push/pull switch outputs
`include "pcsd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Each rising edge on the control pin while enabled advances the internal count that picks the outputs, until it holds at the variant's top.
// - The count reaches the outputs only after the pin stays high for the latch timeout.
// - Counts decode into 64 states, or 32 states when the five-output variant is selected.
// - Output k is off when bit k-1 of count-1 is one or k is above the variant, so count 1 turns all on.
// - Edges at up to 1MHz are counted and no intermediate count shows before the latch.
// - Pulses given one at a time each latch and show their own state in turn.
// - From disabled, the first rising edge enables the device and means all outputs on.
// - After the pin stays low for the 500 us off timeout, outputs go off and the count clears.
// - Off outputs and all outputs while disabled are driven to ground, never floated.
module pulse_count_switch_decoder #(
  parameter int LATCH_CYCLES = `LATCH_CYCLES,
  parameter int OFF_CYCLES   = `OFF_CYCLES
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // Variant strap: high selects five outputs
  input  wire logic       five_out_i,
  // Control pin from the host
  input  wire logic       ctrl_pin_i,
  // Switch outputs, high = on, low = driven to ground
  output logic            switch_output_1_o,
  output logic            switch_output_2_o,
  output logic            switch_output_3_o,
  output logic            switch_output_4_o,
  output logic            switch_output_5_o,
  output logic            switch_output_6_o,
  output logic            enabled_o
);

  // Last value of each timeout; the shared timer is zero on the cycle after the edge
  localparam logic [`TIMER_W-1:0] LATCH_LAST = `TIMER_W'(LATCH_CYCLES - 1);
  localparam logic [`TIMER_W-1:0] OFF_LAST   = `TIMER_W'(OFF_CYCLES - 1);

  // Synchroniser state for the control pin and the variant strap
  logic pin_meta;
  logic pin_sync;
  logic strap_meta;
  logic strap_sync;
  logic next_pin_meta;
  logic next_pin_sync;
  logic next_strap_meta;
  logic next_strap_sync;

  // Two stages per pin; only the second stage reads the first
  always_comb begin
    next_pin_meta   = ctrl_pin_i;
    next_pin_sync   = pin_meta;
    // Strap is meant static, but a board may still move it at any time
    next_strap_meta = five_out_i;
    next_strap_sync = strap_meta;
  end

  // Stages reset to the idle low level of both pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta   <= `PIN_IDLE;
      pin_sync   <= `PIN_IDLE;
      strap_meta <= `PIN_IDLE;
      strap_sync <= `PIN_IDLE;
    end else if (ce_i) begin
      pin_meta   <= next_pin_meta;
      pin_sync   <= next_pin_sync;
      strap_meta <= next_strap_meta;
      strap_sync <= next_strap_sync;
    end
  end

  // Edge detector on the synchronised pin
  logic pin_prev;
  logic next_pin_prev;
  logic rise;
  logic fall;

  // Previous level resets to idle low, so leaving reset makes no false edge
  always_comb begin
    next_pin_prev = pin_sync;
    rise          = pin_sync && !pin_prev;
    fall          = !pin_sync && pin_prev;
  end

  // Edge detector register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_prev <= `PIN_IDLE;
    end else if (ce_i) begin
      pin_prev <= next_pin_prev;
    end
  end

  // Shared run timer; one counter serves both timeouts
  logic [`TIMER_W-1:0] timer;
  logic [`TIMER_W-1:0] next_timer;
  logic                timer_full;
  logic                latch_due;
  logic                off_due;

  // Timer restarts on every edge and stops at all ones instead of wrapping
  always_comb begin
    timer_full = (timer == '1);
    next_timer = timer;
    if (rise || fall) begin
      next_timer = `TIMER_ZERO;
    end else if (!timer_full) begin
      // A wrap would fake a second timeout during a long hold
      next_timer = timer + `TIMER_W'(1);
    end
    latch_due = pin_sync && (timer == LATCH_LAST);
    off_due   = !pin_sync && (timer == OFF_LAST);
  end

  // Timer register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer <= `TIMER_ZERO;
    end else if (ce_i) begin
      timer <= next_timer;
    end
  end

  // Decoder state and edge count; count holds N-1 once enabled
  pcsd_pkg::link_state_t state;
  pcsd_pkg::link_state_t next_state;
  logic [`COUNT_W-1:0]   count;
  logic [`COUNT_W-1:0]   next_count;
  logic [`COUNT_W-1:0]   count_max;
  logic                  load_outs;
  logic                  clear_outs;

  // Small variant tops out at 32 states
  assign count_max = strap_sync ? `OUTS_SMALL_MASK : `COUNT_MAX;

  // Counting and latch decisions; a rising edge wins over a timeout in one cycle
  always_comb begin
    next_state = state;
    next_count = count;
    load_outs  = 1'h0;
    clear_outs = 1'h0;
    unique case (state)
      pcsd_pkg::DISABLED: begin
        // First edge wakes the block and stands for count 1
        if (rise) begin
          next_state = pcsd_pkg::COUNTING;
          next_count = `COUNT_ZERO;
        end
      end
      pcsd_pkg::COUNTING, pcsd_pkg::LATCHED: begin
        if (rise) begin
          // Hold at the top rather than wrap to an unrelated pattern
          if (count < count_max) begin
            next_count = count + `COUNT_W'(1);
          end
          next_state = pcsd_pkg::COUNTING;
        end else if (latch_due && state == pcsd_pkg::COUNTING) begin
          // One latch per high run; further high time changes nothing
          load_outs  = 1'h1;
          next_state = pcsd_pkg::LATCHED;
        end else if (off_due) begin
          clear_outs = 1'h1;
          next_state = pcsd_pkg::DISABLED;
          next_count = `COUNT_ZERO;
        end
      end
      // Unused code of the two-bit state; fall back to disabled
      default: begin
        clear_outs = 1'h1;
        next_state = pcsd_pkg::DISABLED;
        next_count = `COUNT_ZERO;
      end
    endcase
  end

  // State and count registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= pcsd_pkg::DISABLED;
      count <= `COUNT_ZERO;
    end else if (ce_i) begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Per-output decode of the held count
  logic [`COUNT_W-1:0] decoded;

  // Output k is on when bit k-1 of N-1 is clear; bits above the variant stay off
  for (genvar k = 0; k < `COUNT_W; k++) begin : g_decode
    assign decoded[k] = !count[k] && count_max[k];
  end

  // Output register contents
  logic [`COUNT_W-1:0] outs;
  logic [`COUNT_W-1:0] next_outs;

  // Loads only on the latch, so fast pulse trains never show midway
  always_comb begin
    next_outs = outs;
    if (clear_outs) begin
      next_outs = `OUTS_ALL_OFF;
    end else if (load_outs) begin
      next_outs = decoded;
    end
  end

  // Output register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outs <= `OUTS_ALL_OFF;
    end else if (ce_i) begin
      outs <= next_outs;
    end
  end

  // Outputs always driven: low means pulled to ground
  assign switch_output_1_o = outs[0];
  assign switch_output_2_o = outs[1];
  assign switch_output_3_o = outs[2];
  assign switch_output_4_o = outs[3];
  assign switch_output_5_o = outs[4];
  assign switch_output_6_o = outs[5];
  assign enabled_o         = (state != pcsd_pkg::DISABLED);

endmodule // pulse_count_switch_decoder

`default_nettype wire

/* File: testbench/host_pin_model.sv */
// Host pin model: 1MHz pulse trains and holds
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (input wire logic clk_i, output logic ctrl_pin_o);
  initial ctrl_pin_o = 1'b0;
  task automatic level(input logic v, input int n);
    ctrl_pin_o = v;
    repeat (n) @(negedge clk_i);
  endtask
  // Period of 100 clocks; the high part stays short of a latch
  task automatic pulses(input int n);
    for (int i = 0; i < 2 * n; i++) level(i[0], i[0] ? 45 : 55);
  endtask
endmodule // host_pin_model
`default_nettype wire

/* File: testbench/pcsd_properties.sv */
// Port assertions for the switch decoder
`timescale 1ns/1ps
`default_nettype none
module pcsd_properties #(parameter int LATCH_CYCLES = 60, parameter int OFF_CYCLES = 80) (
  input wire logic clk_i, rst_n_i, five_out_i, ctrl_pin_i, enabled_o, switch_output_1_o,
  input wire logic switch_output_2_o, switch_output_3_o, switch_output_4_o,
  input wire logic switch_output_5_o, switch_output_6_o);
  wire logic [5:0] o = {switch_output_6_o, switch_output_5_o, switch_output_4_o,
    switch_output_3_o, switch_output_2_o, switch_output_1_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Run lengths of the pin level, for timeouts too long for a repeat
  int unsigned high_run, low_run;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_run <= 0;
      low_run  <= 0;
    end else begin
      high_run <= ctrl_pin_i ? high_run + 1 : 0;
      low_run  <= ctrl_pin_i ? 0 : low_run + 1;
    end
  end
  chk_off_gnd: assert property (!enabled_o |-> o == 6'h00) else $error("on");
  chk_five_mask: assert property (five_out_i |-> !switch_output_6_o) else $error("six");
  // Sync lag: the decision at an edge sees the pin of two samples before
  chk_stay_on: assert property (enabled_o && ctrl_pin_i && $past(ctrl_pin_i, 2) |=>
    enabled_o) else $error("drop");
  chk_latch_wait: assert property (enabled_o && $changed(o) |->
    $past(high_run, 2) >= LATCH_CYCLES) else $error("early");
  chk_wake_edge: assert property ($rose(enabled_o) |-> $past(ctrl_pin_i, 2))
    else $error("wake");
  chk_off_time: assert property ($fell(enabled_o) |-> $past(low_run, 2) >= OFF_CYCLES)
    else $error("off");
  chk_stay_off: assert property (!ctrl_pin_i [*4] ##0 !enabled_o |=> !enabled_o)
    else $error("rise");
  chk_low_hold: assert property (!ctrl_pin_i [*4] ##0 enabled_o |=>
    $stable(o) || !enabled_o) else $error("moved");
endmodule // pcsd_properties
bind pulse_count_switch_decoder pcsd_properties #(.LATCH_CYCLES(LATCH_CYCLES),
  .OFF_CYCLES(OFF_CYCLES)) chk (.*);
`default_nettype wire

/* File: testbench/pulse_count_switch_decoder_tb_top.sv */
// Self-checking bench for the switch decoder
`timescale 1ns/1ps
`default_nettype none
module pulse_count_switch_decoder_tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, f = 1'b0;
  wire logic p, en;
  wire logic [5:0] o;
  int miscompares = 0, tests_run = 0, total = 0;
  always #5 clk_i = ~clk_i; // 100MHz
  host_pin_model host (.clk_i(clk_i), .ctrl_pin_o(p));
  pulse_count_switch_decoder #(.LATCH_CYCLES(60), .OFF_CYCLES(80)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(1'b1), .five_out_i(f), .ctrl_pin_i(p), .enabled_o(en),
    .switch_output_1_o(o[0]), .switch_output_2_o(o[1]), .switch_output_3_o(o[2]),
    .switch_output_4_o(o[3]), .switch_output_5_o(o[4]), .switch_output_6_o(o[5]));
  task automatic check(input logic [6:0] e);
    tests_run++;
    if ({en, o} !== e) miscompares++;
    if ({en, o} !== e) $display("mismatch outputs expected %h seen %h", e, {en, o});
  endtask
  // Optional drop past the off timeout, then pulses held until latched
  task automatic burst(input int n, input int m, input bit d);
    if (d) host.level(1'b0, 90);
    if (d) check(7'h00);
    f = (m == 32);
    total = d ? n : total + n;
    host.pulses(n);
    host.level(1'b1, 70);
    check({1'b1, ~6'((total > m ? m : total) - 1) & 6'(m - 1)});
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    burst(1, 64, 1'b0);
    burst(1, 64, 1'b0);
    burst(31, 64, 1'b0);
    burst(40, 64, 1'b0);
    burst(40, 32, 1'b1);
    conclude();
  end
  // Watchdog at 20k cycles, well past the run's 12k
  initial begin
    #200000 miscompares++;
    conclude();
  end
endmodule // pulse_count_switch_decoder_tb_top
`default_nettype wire
